// ===== core/ssipt_pkg.sv
// constants, types and helpers for the ssi absolute position transmitter
// assumes a 100 MHz sys_clk; all counts are derived from that period
//
// How it works
// - idle master clock and encoder data line both rest high
// - first falling clock edge after idle captures position and special bit
// - first rising edge of the frame puts the word msb on data
// - every later rising edge moves to the next lower bit
// - after the lsb, data is held low until timeout, then high
// - timeout restarts on each falling edge, nominal 20 us
// - unbroken clocking after a frame resends the same captured word
// - each repeated word is 25 clock bits long
// - pulse 26 after timeout starts a fresh capture instead
// - repetition only for resolutions up to 13 bits
// - position holds up to 16 bits; variants 12, 13 or 16
// - position sent in gray or plain binary, fixed per variant
// - default direction counts down while turning clockwise
// - low level on direction select reverses counting direction
// - direction change reaches sent position within 10 ms
// - no valid frames needed until 250 ms after power up
package ssipt_pkg;

   // clock
   localparam int CLK_PERIOD_NS = 10;

   // frame layout
   localparam int FRAME_BITS = 25;
   localparam int MAX_POS_BITS = 16;
   localparam int RING_MAX_BITS = 13;
   localparam int BIT_IDX_W = 5;
   localparam logic [BIT_IDX_W-1:0] LAST_BIT_IDX = 5'h18;
   localparam logic [BIT_IDX_W-1:0] FIRST_BIT_IDX = 5'h00;

   // timing: figures in their own unit, counts derived
   localparam int MONO_TIME_US = 20;
   localparam int MONO_CYC = MONO_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int POWERUP_TIME_MS = 250;
   localparam int POWERUP_CYC = POWERUP_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int DIR_SETTLE_TIME_MS = 1;
   localparam int DIR_SETTLE_CYC =
      DIR_SETTLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TMR_W = 25;

   // line and reset levels
   localparam logic LINE_IDLE = 1'b1;
   localparam logic LINE_TAIL = 1'b0;
   localparam logic DIR_SEL_INACTIVE = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_SHIFT,
      ST_TAIL
   } ssipt_state_e;

   // differential data pair toward the master
   typedef struct packed {
      logic dataPos;
      logic dataNeg;
   } ssipt_line_s;

   // sensor sample: raw angle rising clockwise, plus special bit
   typedef struct packed {
      logic [MAX_POS_BITS-1:0] angle;
      logic special;
   } ssipt_sample_s;

   // binary to gray
   function automatic logic [MAX_POS_BITS-1:0] binToGray(
      input logic [MAX_POS_BITS-1:0] b);
      binToGray = b ^ (b >> 1);
   endfunction : binToGray

endpackage : ssipt_pkg

// ===== core/ssipt_sync.sv
// two flip-flop synchroniser for pins from outside the sys_clk domain
// assumes inputs are slow levels or clocks well below sys_clk / 4
`timescale 1ns/100ps
`default_nettype none
module ssipt_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // pins
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage1_d;
   logic [WIDTH-1:0] stage2_d;

   // first stage is read only by the second
   always_comb begin
      stage1_d = asyncIn;
      stage2_d = stage1_q;
   end

   // resets to idle high level of the link pins
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stage1_q <= '1;
         stage2_q <= '1;
      end else begin
         stage1_q <= stage1_d;
         stage2_q <= stage2_d;
      end
   end

   assign syncOut = stage2_q;
endmodule : ssipt_sync
`default_nettype wire

// ===== core/ssipt_timer.sv
// retriggerable down-counting one-shot timer
// assumes load values fit in the package timer width
`timescale 1ns/100ps
`default_nettype none
module ssipt_timer (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // control
   input wire logic load,
   input wire logic [ssipt_pkg::TMR_W-1:0] loadValue,
   // status
   output logic running,
   output logic expired
);
   import ssipt_pkg::*;

   logic [TMR_W-1:0] count_q;
   logic [TMR_W-1:0] count_d;
   logic expired_q;
   logic expired_d;

   // load wins over expiry; expiry is a one-cycle pulse
   always_comb begin
      count_d = count_q;
      expired_d = 1'b0;
      if (load) begin
         count_d = loadValue;
      end else if (count_q != '0) begin
         count_d = count_q - 1'b1;
         expired_d = (count_q == {{(TMR_W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count_q <= '0;
         expired_q <= 1'b0;
      end else begin
         count_q <= count_d;
         expired_q <= expired_d;
      end
   end

   assign running = (count_q != '0);
   assign expired = expired_q;
endmodule : ssipt_timer
`default_nettype wire

// ===== core/ssipt_transmitter.sv
// encoder end of a synchronous serial position link
// assumes the master clock pin is sampled by sys_clk at 100 MHz and that
// the sensor sample comes from logic on sys_clk, stable between edges
`timescale 1ns/100ps
`default_nettype none
module ssipt_transmitter #(
   parameter int POS_BITS = 13,
   parameter bit GRAY_CODE = 1'b1,
   parameter int POWERUP_LEN = ssipt_pkg::POWERUP_CYC,
   parameter int DIR_SETTLE_LEN = ssipt_pkg::DIR_SETTLE_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // link from the master
   input wire logic linkClk,
   // link toward the master
   output ssipt_pkg::ssipt_line_s linkOut,
   // position sensor
   input wire ssipt_pkg::ssipt_sample_s sample,
   // direction select pin, active low
   input wire logic dirSelN,
   // status
   output logic ready,
   output logic ringActive,
   output logic frameBusy
);
   import ssipt_pkg::*;

   // repetition allowed only for the narrow variants
   localparam bit RING_OK = (POS_BITS <= RING_MAX_BITS);
   localparam int PAD_SHIFT = MAX_POS_BITS - POS_BITS;

   // synchronised pins
   logic [1:0] pinSync;
   logic clkSync;
   logic dirSync;

   // clock edge detection
   logic clkPrev_q;
   logic clkPrev_d;
   logic riseEdge;
   logic fallEdge;

   // frame state
   ssipt_state_e state_q;
   ssipt_state_e state_d;
   logic [BIT_IDX_W-1:0] bitIdx_q;
   logic [BIT_IDX_W-1:0] bitIdx_d;
   logic [FRAME_BITS-1:0] word_q;
   logic [FRAME_BITS-1:0] word_d;
   logic data_q;
   logic data_d;
   logic ring_q;
   logic ring_d;

   // monoflop timer
   logic monoLoad;
   logic monoRunning;
   logic monoExpired;

   // power up gate
   logic started_q;
   logic started_d;
   logic ready_q;
   logic ready_d;
   logic powerExpired;

   // direction filter
   logic dirPend_q;
   logic dirPend_d;
   logic dirStable_q;
   logic dirStable_d;
   logic dirLoad;
   logic dirExpired;

   // sequencer decodes
   logic captureReq;
   logic lastBit;
   logic ringReq;
   logic [BIT_IDX_W-1:0] nextIdx;
   logic [FRAME_BITS-1:0] freshWord;

   // build the 25 bit word: pad zeros, position, special bit at the lsb
   function automatic logic [FRAME_BITS-1:0] buildWord(
      input logic [MAX_POS_BITS-1:0] angle,
      input logic special,
      input logic reversed);
      logic [MAX_POS_BITS-1:0] oriented;
      logic [MAX_POS_BITS-1:0] scaled;
      logic [MAX_POS_BITS-1:0] coded;
      logic [FRAME_BITS-1:0] w;
      oriented = '0;
      scaled = '0;
      coded = '0;
      w = '0;
      // raw angle rises clockwise, so the default sends its complement
      oriented = reversed ? angle : ~angle;
      // keep the top bits of the angle for the chosen resolution
      scaled = oriented >> PAD_SHIFT;
      coded = GRAY_CODE ? binToGray(scaled) : scaled;
      w[0] = special;
      for (int i = 0; i < POS_BITS; i++) begin
         w[i+1] = coded[i];
      end
      buildWord = w;
   endfunction : buildWord

   // pick the bit presented for a given index, msb first
   function automatic logic pickBit(
      input logic [FRAME_BITS-1:0] w,
      input logic [BIT_IDX_W-1:0] idx);
      logic [BIT_IDX_W-1:0] pos;
      pos = '0;
      pos = LAST_BIT_IDX - idx;
      pickBit = w[pos];
   endfunction : pickBit

   // true in the slot that holds the special bit, the lsb
   function automatic logic isLastBit(
      input logic [BIT_IDX_W-1:0] idx);
      isLastBit = (idx == LAST_BIT_IDX);
   endfunction : isLastBit

   // link clock and direction pin pass two flip-flops first
   ssipt_sync #(
      .WIDTH(2)
   ) u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .asyncIn({linkClk, dirSelN}),
      .syncOut(pinSync)
   );

   assign clkSync = pinSync[1];
   assign dirSync = pinSync[0];

   // edges of the synchronised master clock
   always_comb begin
      clkPrev_d = clkSync;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         clkPrev_q <= LINE_IDLE;
      end else begin
         clkPrev_q <= clkPrev_d;
      end
   end

   assign riseEdge = clkSync & ~clkPrev_q;
   assign fallEdge = ~clkSync & clkPrev_q;

   // monoflop, retriggered by every falling edge inside a frame
   ssipt_timer u_mono (
      .sys_clk(sys_clk),
      .reset(reset),
      .load(monoLoad),
      .loadValue(TMR_W'(MONO_CYC)),
      .running(monoRunning),
      .expired(monoExpired)
   );

   // power up delay, started once after reset release
   ssipt_timer u_power (
      .sys_clk(sys_clk),
      .reset(reset),
      .load(~started_q),
      .loadValue(TMR_W'(POWERUP_LEN)),
      .running(),
      .expired(powerExpired)
   );

   // direction pin must hold still for the settle time
   ssipt_timer u_dir (
      .sys_clk(sys_clk),
      .reset(reset),
      .load(dirLoad),
      .loadValue(TMR_W'(DIR_SETTLE_LEN)),
      .running(),
      .expired(dirExpired)
   );

   // power up gate next state
   always_comb begin
      started_d = 1'b1;
      ready_d = ready_q | powerExpired;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         started_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         started_q <= started_d;
         ready_q <= ready_d;
      end
   end

   // direction filter: adopt the pin level once it has settled
   always_comb begin
      dirPend_d = dirSync;
      dirLoad = (dirSync != dirPend_q);
      dirStable_d = dirStable_q;
      if (dirExpired) begin
         dirStable_d = dirPend_q;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dirPend_q <= DIR_SEL_INACTIVE;
         dirStable_q <= DIR_SEL_INACTIVE;
      end else begin
         dirPend_q <= dirPend_d;
         dirStable_q <= dirStable_d;
      end
   end

   // a fall only starts a frame once the power up delay is over
   assign captureReq = fallEdge & ready_q;
   // lsb slot reached: the next fall closes the word
   assign lastBit = isLastBit(bitIdx_q);
   // index of the bit shown at the next rise
   assign nextIdx = bitIdx_q + 1'b1;
   // a rise in the tail repeats the word on narrow variants
   assign ringReq = riseEdge & RING_OK;
   // word built from the sensor, stored only on a capture
   assign freshWord = buildWord(sample.angle, sample.special,
      ~dirStable_q);

   // captured word: loaded on the leading fall, kept for repeats
   always_comb begin
      word_d = word_q;
      if ((state_q == ST_IDLE) && captureReq) begin
         word_d = freshWord;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         word_q <= '0;
      end else begin
         word_q <= word_d;
      end
   end

   // repeat flag: set when a repeat starts, cleared back in idle
   always_comb begin
      ring_d = ring_q;
      if (state_q == ST_IDLE) begin
         ring_d = 1'b0;
      end else if ((state_q == ST_TAIL) && ringReq) begin
         ring_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ring_q <= 1'b0;
      end else begin
         ring_q <= ring_d;
      end
   end

   // frame sequencer next state
   always_comb begin
      state_d = state_q;
      bitIdx_d = bitIdx_q;
      data_d = data_q;
      monoLoad = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            // line rests high between frames
            data_d = LINE_IDLE;
            if (captureReq) begin
               // leading edge: word is stored, timer started
               monoLoad = 1'b1;
               state_d = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (riseEdge) begin
               data_d = pickBit(word_q, FIRST_BIT_IDX);
               bitIdx_d = FIRST_BIT_IDX;
               state_d = ST_SHIFT;
            end else if (monoExpired) begin
               // master gave up before the first bit
               data_d = LINE_IDLE;
               state_d = ST_IDLE;
            end
         end
         ST_SHIFT: begin
            if (riseEdge && !lastBit) begin
               bitIdx_d = nextIdx;
               data_d = pickBit(word_q, nextIdx);
            end else if (fallEdge) begin
               // falling edges only retrigger, never capture
               monoLoad = 1'b1;
               if (lastBit) begin
                  // lsb done after the 25th bit
                  data_d = LINE_TAIL;
                  state_d = ST_TAIL;
               end
            end else if (monoExpired) begin
               // clock too slow: frame ends, line back high
               data_d = LINE_IDLE;
               state_d = ST_IDLE;
            end
         end
         ST_TAIL: begin
            data_d = LINE_TAIL;
            if (ringReq) begin
               // unbroken clocking resends the same stored word
               bitIdx_d = FIRST_BIT_IDX;
               data_d = pickBit(word_q, FIRST_BIT_IDX);
               state_d = ST_SHIFT;
            end else if (fallEdge) begin
               // extra pulses on wide variants only retrigger
               monoLoad = 1'b1;
            end else if (monoExpired) begin
               // next falling edge captures afresh from idle
               data_d = LINE_IDLE;
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   // frame sequencer registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
         bitIdx_q <= FIRST_BIT_IDX;
         data_q <= LINE_IDLE;
      end else begin
         state_q <= state_d;
         bitIdx_q <= bitIdx_d;
         data_q <= data_d;
      end
   end

   // outputs: data pair straight from the flop, inverse on the minus wire
   assign linkOut.dataPos = data_q;
   assign linkOut.dataNeg = ~data_q;
   assign ready = ready_q;
   assign ringActive = ring_q;
   assign frameBusy = (state_q != ST_IDLE) | monoRunning;

endmodule : ssipt_transmitter
`default_nettype wire

// ===== tb/ssipt_props.sv
// port assertions for the position transmitter
// assumes link clock pulses of at least four sys_clk cycles
`timescale 1ns/100ps
`default_nettype none
module ssipt_props #(
   parameter int POWERUP_LEN = 50
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // link
   input wire logic linkClk,
   input wire ssipt_pkg::ssipt_line_s linkOut,
   // pins
   input wire ssipt_pkg::ssipt_sample_s sample,
   input wire logic dirSelN,
   // status
   input wire logic ready,
   input wire logic ringActive,
   input wire logic frameBusy
);
   import ssipt_pkg::*;
   logic [15:0] riseAge_q;
   logic [15:0] riseAge_d;
   logic [15:0] fallAge_q;
   logic [15:0] fallAge_d;
   logic [31:0] upAge_q;
   logic [31:0] upAge_d;
   logic linkClk_q;

   // saturating ages of link edges and of reset release
   always_comb begin
      riseAge_d = riseAge_q + {15'h0, ~riseAge_q[15]};
      fallAge_d = fallAge_q + {15'h0, ~fallAge_q[15]};
      upAge_d = upAge_q + {31'h0, ~upAge_q[31]};
      if (linkClk && !linkClk_q) begin
         riseAge_d = 16'h0;
      end
      if (!linkClk && linkClk_q) begin
         fallAge_d = 16'h0;
      end
   end

   // age registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         riseAge_q <= 16'h8000;
         fallAge_q <= 16'h8000;
         upAge_q <= 32'h0;
         linkClk_q <= LINE_IDLE;
      end else begin
         riseAge_q <= riseAge_d;
         fallAge_q <= fallAge_d;
         upAge_q <= upAge_d;
         linkClk_q <= linkClk;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   a_pair_compl: assert property (
      linkOut.dataNeg == !linkOut.dataPos) else $error("pair not inverse");
   a_idle_high: assert property (
      !frameBusy [*2] |-> linkOut.dataPos) else $error("idle data low");
   a_quiet_early: assert property (
      !ready |-> linkOut.dataPos) else $error("data before ready");
   a_ready_late: assert property (
      ready |-> upAge_q >= 32'(POWERUP_LEN)) else $error("ready too soon");
   a_data_on_edge: assert property (
      $changed(linkOut.dataPos) |-> riseAge_q <= 16'h8
      || fallAge_q <= 16'h8 || fallAge_q >= 16'd1000)
      else $error("data moved off edge");
   a_tail_span: assert property (
      $rose(linkOut.dataPos) && riseAge_q > 16'h8 && fallAge_q > 16'h8
      |-> fallAge_q inside {[16'd1000:16'd3000]}) else $error("tail length");
   a_busy_on_fall: assert property (
      $fell(linkClk) && ready |-> ##[1:8] frameBusy)
      else $error("fall not taken");
   a_busy_end: assert property (
      $fell(frameBusy) |-> fallAge_q >= 16'd1000) else $error("early idle");
   a_ring_start: assert property (
      $rose(ringActive) |-> riseAge_q <= 16'h8) else $error("ring off edge");

   c_ring: cover property ($rose(ringActive));
   c_tail: cover property ($rose(linkOut.dataPos) && fallAge_q > 16'd999);
   c_ready: cover property ($rose(ready));
   c_rev_frame: cover property (!dirSelN && $rose(frameBusy));
   c_special: cover property ($rose(frameBusy) && sample.special);
endmodule : ssipt_props

bind ssipt_transmitter ssipt_props #(.POWERUP_LEN(POWERUP_LEN)) ssipt_props_inst (
   .sys_clk(sys_clk), .reset(reset), .linkClk(linkClk), .linkOut(linkOut),
   .sample(sample), .dirSelN(dirSelN), .ready(ready),
   .ringActive(ringActive), .frameBusy(frameBusy));
`default_nettype wire

// ===== tb/ssipt_master_model.sv
// behavioural serial master making clock bursts and reading words
// assumes the bench calls burst only from one process at a time
`timescale 1ns/100ps
`default_nettype none
module ssipt_master_model (
   // link
   output var logic linkClk,
   input wire logic dataPos,
   // received words
   output var logic [24:0] rxWord,
   output var int rxCount
);
   import ssipt_pkg::*;
   int nBits;
   logic [24:0] shift;

   // clock rests high between bursts
   initial begin
      linkClk = LINE_IDLE;
      rxWord = 25'h0;
      rxCount = 0;
      shift = 25'h0;
   end

   // n pulses of given half period, one word per 25 samples
   task automatic burst(input int n, input realtime half);
      int w;
      w = 0;
      while (dataPos !== LINE_IDLE && w < 5000) begin
         #100;
         w++;
      end
      nBits = 0;
      for (int k = 1; k <= n; k++) begin
         linkClk = 1'b0;
         if (k > 1) begin
            shift = {shift[23:0], dataPos};
            nBits++;
            if (nBits % FRAME_BITS == 0) begin
               rxWord = shift;
               rxCount++;
            end
         end
         #(half);
         linkClk = 1'b1;
         #(half);
      end
   endtask : burst
endmodule : ssipt_master_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the position transmitter
// assumes the master model and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import ssipt_pkg::*;
   localparam int POS_BITS = 13;
   localparam int PWR_LEN = 50;
   localparam int DIR_LEN = 20;
   logic sys_clk;
   logic reset;
   logic linkClk;
   logic dirSelN;
   logic ready;
   logic ringActive;
   logic frameBusy;
   ssipt_line_s linkOut;
   ssipt_sample_s sample;
   logic [24:0] rxWord;
   int rxCount;
   int seen;
   int err_total;
   int tests_run;
   int seed;
   logic [24:0] expQ[$];

   ssipt_transmitter #(.POS_BITS(POS_BITS), .GRAY_CODE(1'b1),
      .POWERUP_LEN(PWR_LEN), .DIR_SETTLE_LEN(DIR_LEN)) ssipt_transmitter_inst (
      .sys_clk(sys_clk), .reset(reset), .linkClk(linkClk), .linkOut(linkOut),
      .sample(sample), .dirSelN(dirSelN), .ready(ready),
      .ringActive(ringActive), .frameBusy(frameBusy));
   ssipt_master_model ssipt_master_model_inst (.linkClk(linkClk),
      .dataPos(linkOut.dataPos), .rxWord(rxWord), .rxCount(rxCount));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [24:0] got, input logic [24:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // expected word: zero pad, oriented gray position, special bit
   function automatic logic [24:0] expWord(input logic [16:0] r,
      input logic rev);
      logic [15:0] o;
      logic [POS_BITS-1:0] p;
      o = rev ? r[16:1] : ~r[16:1];
      p = o[15 -: POS_BITS];
      return {{(24-POS_BITS){1'b0}}, p ^ (p >> 1), r[0]};
   endfunction : expWord

   // clocks out w words of one capture while the sensor moves on
   task automatic readFrame(input logic [16:0] r, input realtime half,
      input int w);
      int n;
      tick(1);
      sample = r;
      repeat (w) expQ.push_back(expWord(r, !dirSelN));
      fork
         ssipt_master_model_inst.burst(w * FRAME_BITS + 1, half);
         begin
            #1000;
            tick(1);
            sample = ~r;
         end
      join
      if (w > 1) check(25'(ringActive), 25'h1);
      tick(1);
      check(25'(linkOut), 25'h1);
      n = 0;
      while (linkOut.dataPos !== LINE_IDLE && n < 4000) begin
         tick(1);
         n++;
      end
      // tail reckoned from the last fall, two half periods before the loop
      n = n + $rtoi(half / 5.0);
      check(25'(n > 1000 && n < 3000), 25'h1);
      check(25'(frameBusy), 25'h0);
      $display("frame test done, %0d words", w);
   endtask : readFrame

   // compares each received word with the oldest expectation
   always @(posedge sys_clk) begin
      if (rxCount != seen) begin
         seen = rxCount;
         // a word with no note behind it is a mismatch too
         check(25'(expQ.size() != 0), 25'h1);
         if (expQ.size() != 0) begin
            check(rxWord, expQ.pop_front());
         end
      end
   end

   // main sequence
   initial begin
      logic [16:0] r;
      int n;
      seed = 32'hbd5d;
      reset = 1'b1;
      dirSelN = DIR_SEL_INACTIVE;
      sample = '0;
      seen = 0;
      err_total = 0;
      tests_run = 0;
      tick(16);
      check({20'h0, linkOut, ready, ringActive, frameBusy}, 25'h10);
      reset = 1'b0;
      ssipt_master_model_inst.burst(2, 62.5);
      check(25'(linkOut.dataPos), 25'h1);
      for (n = 0; n < PWR_LEN + 20 && ready !== 1'b1; n++) tick(1);
      check(25'(ready), 25'h1);
      for (n = 0; n < 3000 && frameBusy !== 1'b0; n++) tick(1);
      $display("reset test done");
      readFrame(17'h0, 62.5, 1);
      readFrame(17'h1ffff, 62.5, 1);
      repeat (4) begin
         r = 17'($random(seed));
         readFrame(r, 62.5, 1);
      end
      dirSelN = 1'b0;
      tick(DIR_LEN + 10);
      r = 17'($random(seed));
      readFrame(r, 62.5, 1);
      dirSelN = DIR_SEL_INACTIVE;
      tick(DIR_LEN + 10);
      readFrame(r, 62.5, 2);
      readFrame(~r, 2000.0, 1);
      check(25'(expQ.size()), 25'h0);
      end_sim();
   end

   // watchdog: tests take about 32k cycles, give up at 60k
   initial begin
      #600000;
      err_total++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
